// ---- rtl/mbd_decoder.sv ----
/*
 * Memory bank decoder with on-chip six-bit processor port.
 * Assumes the processor core presents address, strobes and write data
 * synchronous to core_clk_i; cartridge lines and cassette sense are pins.
 */
`timescale 1ns/1ns
module mbd_decoder (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        game_n_i,
   input  wire logic        exrom_n_i,
   input  wire logic        cass_sense_i,
   output logic [7:0]       port_rdata_o,
   output logic             port_sel_o,
   output logic             ram_cs_o,
   output logic             ram_we_o,
   output logic             lower_rom_cs_o,
   output logic             upper_rom_cs_o,
   output logic             char_rom_cs_o,
   output logic             cart_lo_cs_o,
   output logic             cart_hi_cs_o,
   output logic             video_cs_o,
   output logic             sound_cs_o,
   output logic             colour_cs_o,
   output logic             colour_nybble_o,
   output logic             keyb_cs_o,
   output logic             serial_cs_o,
   output logic             slot1_cs_o,
   output logic             slot2_cs_o,
   output logic [5:0]       port_out_o,
   output logic [5:0]       port_oe_n_o,
   output logic             cass_write_o,
   output logic             cass_motor_o
);

   // ****************************************************
   // Port registers
   // ****************************************************
   logic [7:0] dir_reg;
   logic [7:0] data_reg;
   logic [7:0] port_rdata_reg;
   logic       game_meta_reg;
   logic       game_reg;
   logic       exrom_meta_reg;
   logic       exrom_reg;
   logic       sense_meta_reg;
   logic       sense_reg;
   logic       dir_hit;
   logic       data_hit;

   assign dir_hit  = (addr_i == mbd_pkg::DIR_ADDR);
   assign data_hit = (addr_i == mbd_pkg::DATA_ADDR);

   // Direction register, reset so banking lines drive at once
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         dir_reg <= mbd_pkg::DIR_RESET;
      end else if (wr_i && dir_hit) begin
         dir_reg <= wdata_i & mbd_pkg::PORT_MASK;
      end
   end

   // Output latch keeps its value while a bit is an input
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         data_reg <= mbd_pkg::DATA_RESET;
      end else if (wr_i && data_hit) begin
         data_reg <= wdata_i & mbd_pkg::PORT_MASK;
      end
   end

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         game_meta_reg  <= 1'b1;
         game_reg       <= 1'b1;
         exrom_meta_reg <= 1'b1;
         exrom_reg      <= 1'b1;
         sense_meta_reg <= 1'b0;
         sense_reg      <= 1'b0;
      end else begin
         game_meta_reg  <= game_n_i;
         game_reg       <= game_meta_reg;
         exrom_meta_reg <= exrom_n_i;
         exrom_reg      <= exrom_meta_reg;
         sense_meta_reg <= cass_sense_i;
         sense_reg      <= sense_meta_reg;
      end
   end

   // ****************************************************
   // Effective port levels
   // ****************************************************
   logic [5:0] port_level;
   logic [5:0] pin_in;

   always_comb begin
      pin_in = 6'h3F;
      pin_in[mbd_pkg::CASS_SENSE_BIT] = sense_reg;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_port
         // Output bits follow the latch, input bits the pin
         assign port_level[gi] = dir_reg[gi] ? data_reg[gi]
                                             : pin_in[gi];
         assign port_out_o[gi]  = data_reg[gi];
         assign port_oe_n_o[gi] = ~dir_reg[gi];
      end
   endgenerate

   assign cass_write_o = port_level[mbd_pkg::CASS_WR_BIT];
   assign cass_motor_o = port_level[mbd_pkg::CASS_MOTOR_BIT];

   // Read-back of the direction register or of the effective port levels
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         port_rdata_reg <= 8'h00;
      end else if (rd_i && dir_hit) begin
         port_rdata_reg <= dir_reg;
      end else if (rd_i && data_hit) begin
         port_rdata_reg <= {2'h0, port_level};
      end
   end

   assign port_rdata_o = port_rdata_reg;
   assign port_sel_o   = (rd_i || wr_i) && (dir_hit || data_hit);

   // ****************************************************
   // Bank decode
   // ****************************************************
   logic lo_rom;
   logic hi_rom;
   logic chr_io;
   logic game_n;
   logic exrom_n;
   logic game_map;
   mbd_pkg::mbd_target_type target;

   assign lo_rom  = port_level[mbd_pkg::LOWER_ROM_BIT];
   assign hi_rom  = port_level[mbd_pkg::UPPER_ROM_BIT];
   assign chr_io  = port_level[mbd_pkg::CHAR_IO_BIT];
   assign game_n  = game_reg;
   assign exrom_n = exrom_reg;
   // Game-cartridge map: only cartridge game line low
   assign game_map = !game_n && exrom_n;

   always_comb begin
      target = mbd_pkg::MBD_T_RAM;
      if (game_map) begin
         // Only 4K low RAM seen; cartridge RAM ignored
         case (addr_i[15:12])
            4'h0: target = mbd_pkg::MBD_T_RAM;
            4'h8, 4'h9: target = mbd_pkg::MBD_T_CART_LO;
            4'hD: target = mbd_pkg::MBD_T_IO;
            4'hE, 4'hF: target = mbd_pkg::MBD_T_CART_HI;
            default: target = mbd_pkg::MBD_T_OPEN;
         endcase
      end else begin
         case (addr_i[15:12])
            4'h8, 4'h9: begin
               // Autostart header read from cartridge here
               if (!exrom_n && lo_rom && hi_rom) begin
                  target = mbd_pkg::MBD_T_CART_LO;
               end
            end
            4'hA, 4'hB: begin
               if (lo_rom && hi_rom) begin
                  target = game_n ? mbd_pkg::MBD_T_LOWER_ROM
                                  : mbd_pkg::MBD_T_CART_HI;
               end
            end
            4'hD: begin
               // No ROM banked in means no I/O, RAM shows through
               if (lo_rom || hi_rom) begin
                  target = chr_io ? mbd_pkg::MBD_T_IO
                                  : mbd_pkg::MBD_T_CHAR_ROM;
               end
            end
            4'hE, 4'hF: begin
               if (hi_rom) begin
                  target = mbd_pkg::MBD_T_UPPER_ROM;
               end
            end
            default: target = mbd_pkg::MBD_T_RAM;
         endcase
      end
   end

   // ****************************************************
   // Selects
   // ****************************************************
   logic access;
   logic io_window;
   logic rom_target;

   assign access    = (rd_i || wr_i) && !(dir_hit || data_hit);
   assign io_window = access && (target == mbd_pkg::MBD_T_IO);
   assign rom_target = (target == mbd_pkg::MBD_T_LOWER_ROM)
                    || (target == mbd_pkg::MBD_T_UPPER_ROM)
                    || (target == mbd_pkg::MBD_T_CHAR_ROM)
                    || (target == mbd_pkg::MBD_T_CART_LO)
                    || (target == mbd_pkg::MBD_T_CART_HI);

   always_comb begin
      // Writes under ROM fall into RAM outside the game map; reads see ROM
      ram_cs_o = access && ((target == mbd_pkg::MBD_T_RAM)
                 || (wr_i && rom_target && !game_map));
      ram_we_o = ram_cs_o && wr_i;
      lower_rom_cs_o = access && rd_i
                    && (target == mbd_pkg::MBD_T_LOWER_ROM);
      upper_rom_cs_o = access && rd_i
                    && (target == mbd_pkg::MBD_T_UPPER_ROM);
      char_rom_cs_o  = access && rd_i
                    && (target == mbd_pkg::MBD_T_CHAR_ROM);
      cart_lo_cs_o   = access && (target == mbd_pkg::MBD_T_CART_LO)
                    && (rd_i || game_map);
      cart_hi_cs_o   = access && (target == mbd_pkg::MBD_T_CART_HI)
                    && (rd_i || game_map);
   end

   // Colour RAM drives only the low four data bits
   assign colour_nybble_o = colour_cs_o;

   mbd_io_select u_io_select (
      .io_window_i (io_window),
      .offset_i    (addr_i[11:0]),
      .video_cs_o  (video_cs_o),
      .sound_cs_o  (sound_cs_o),
      .colour_cs_o (colour_cs_o),
      .keyb_cs_o   (keyb_cs_o),
      .serial_cs_o (serial_cs_o),
      .slot1_cs_o  (slot1_cs_o),
      .slot2_cs_o  (slot2_cs_o)
   );

endmodule : mbd_decoder

// ---- pkg/mbd_pkg.sv ----
/*
 * Constants, types and address map for the memory bank decoder.
 * Assumes a 16-bit address, 8-bit data processor bus on one clock.
 */

package mbd_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [15:0] DIR_ADDR      = 16'h0000;
   localparam logic [15:0] DATA_ADDR     = 16'h0001;
   localparam logic [7:0]  DIR_RESET     = 8'h2F;
   localparam logic [7:0]  DATA_RESET    = 8'h3F;
   localparam logic [7:0]  PORT_MASK     = 8'h3F;

   // ****************************************************
   // Port bit positions
   // ****************************************************
   localparam int LOWER_ROM_BIT = 0;
   localparam int UPPER_ROM_BIT = 1;
   localparam int CHAR_IO_BIT   = 2;
   localparam int CASS_WR_BIT   = 3;
   localparam int CASS_SENSE_BIT = 4;
   localparam int CASS_MOTOR_BIT = 5;

   // ****************************************************
   // Cartridge header
   // ****************************************************
   localparam logic [15:0] CART_COLD_ADDR = 16'h8000;
   localparam logic [15:0] CART_WARM_ADDR = 16'h8002;
   localparam logic [15:0] CART_SIG_ADDR  = 16'h8004;
   localparam int          CART_HDR_LEN   = 9;

   // ****************************************************
   // Region targets
   // ****************************************************
   typedef enum logic [3:0] {
      MBD_T_RAM,
      MBD_T_LOWER_ROM,
      MBD_T_UPPER_ROM,
      MBD_T_CHAR_ROM,
      MBD_T_IO,
      MBD_T_CART_LO,
      MBD_T_CART_HI,
      MBD_T_OPEN
   } mbd_target_type;

endpackage : mbd_pkg

// ---- rtl/mbd_io_select.sv ----
/*
 * Chip selects inside the 4K I/O window.
 * Assumes io_window_i is already qualified by the bank decode.
 */
`timescale 1ns/1ns
module mbd_io_select (
   input  wire logic        io_window_i,
   input  wire logic [11:0] offset_i,
   output logic             video_cs_o,
   output logic             sound_cs_o,
   output logic             colour_cs_o,
   output logic             keyb_cs_o,
   output logic             serial_cs_o,
   output logic             slot1_cs_o,
   output logic             slot2_cs_o
);

   // ****************************************************
   // Decode on the top address bits
   // ****************************************************
   always_comb begin
      video_cs_o  = io_window_i && (offset_i[11:10] == 2'h0);
      sound_cs_o  = io_window_i && (offset_i[11:10] == 2'h1);
      colour_cs_o = io_window_i && (offset_i[11:10] == 2'h2);
      keyb_cs_o   = io_window_i && (offset_i[11:8] == 4'hC);
      serial_cs_o = io_window_i && (offset_i[11:8] == 4'hD);
      slot1_cs_o  = io_window_i && (offset_i[11:8] == 4'hE);
      slot2_cs_o  = io_window_i && (offset_i[11:8] == 4'hF);
   end

endmodule : mbd_io_select

// ---- test/mbd_decoder_sva.sv ----
/* Checker on the memory bank decoder ports.
   Assumes it is bound from the testbench top; one clock, sync reset. */
`timescale 1ns/1ns
module mbd_decoder_sva (
   input wire logic        core_clk_i,
   input wire logic        reset_n_i,
   input wire logic [15:0] addr_i,
   input wire logic        rd_i,
   input wire logic        wr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic        game_n_i,
   input wire logic [7:0]  port_rdata_o,
   input wire logic        port_sel_o,
   input wire logic        ram_cs_o,
   input wire logic        ram_we_o,
   input wire logic        lower_rom_cs_o,
   input wire logic        video_cs_o,
   input wire logic        colour_cs_o,
   input wire logic        colour_nybble_o,
   input wire logic        keyb_cs_o,
   input wire logic [5:0]  port_oe_n_o,
   input wire logic        cass_write_o,
   input wire logic        cass_motor_o
);
   logic [7:0] wd_q;
   always_ff @(posedge core_clk_i) wd_q <= wdata_i;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_dir_wr; wr_i && addr_i == 16'h0000; endsequence
   sequence s_dir_rd; rd_i && !wr_i && addr_i == 16'h0000; endsequence
   property p_dir_rd; s_dir_wr ##1 s_dir_rd
      |=> port_rdata_o == ($past(wdata_i, 2) & 8'h3F); endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("dir read");
   property p_oe; s_dir_wr |=> port_oe_n_o == ~wd_q[5:0]; endproperty
   a_oe: assert property (p_oe) else $error("direction");
   property p_rst; $rose(reset_n_i)
      |-> port_oe_n_o == 6'h10 && cass_motor_o; endproperty
   a_rst: assert property (p_rst) else $error("reset port");
   property p_romwr; game_n_i && wr_i && addr_i[15:13] == 3'h5
      |-> ram_we_o && !lower_rom_cs_o; endproperty
   a_romwr: assert property (p_romwr) else $error("rom write");
   property p_sel; (rd_i || wr_i) && addr_i[15:1] == 15'h0000
      |-> port_sel_o && !ram_cs_o; endproperty
   a_sel: assert property (p_sel) else $error("port select");
   property p_io; $onehot0({video_cs_o, colour_cs_o, keyb_cs_o}); endproperty
   a_io: assert property (p_io) else $error("io overlap");
   property p_col; colour_cs_o
      |-> addr_i[15:10] == 6'h36 && colour_nybble_o; endproperty
   a_col: assert property (p_col) else $error("colour select");
   property p_kb; keyb_cs_o |-> addr_i[15:8] == 8'hDC; endproperty
   a_kb: assert property (p_kb) else $error("keyb select");
   property p_cass; wr_i && addr_i == 16'h0001 && !port_oe_n_o[3]
      |=> cass_write_o == wd_q[3]; endproperty
   a_cass: assert property (p_cass) else $error("cass write");
endmodule : mbd_decoder_sva

// ---- test/mbd_core_model.sv ----
/* Processor core model issuing single-cycle reads and writes.
   Assumes the decoder samples strobes on the rising clock edge. */
`timescale 1ns/1ns
module mbd_core_model (
   input  wire logic   clk_i,
   output logic [15:0] addr_o,
   output logic        rd_o,
   output logic        wr_o,
   output logic [7:0]  wdata_o
);
   initial begin
      addr_o = 16'hFFFF;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
   end
   task automatic bus(input logic [15:0] a, input logic r, w,
                      input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o = r;
      wr_o = w;
      wdata_o = d;
   endtask : bus
   // Released bus shows inverted lines, never the stale value
   task automatic idle;
      bus(~addr_o, 1'b0, 1'b0, ~wdata_o);
   endtask : idle
endmodule : mbd_core_model

// ---- test/tb_memory_bank_decoder.sv ----
/* Self-checking bench for the memory bank decoder.
   Assumes the core model drives the bus and the checker is bound. */
`timescale 1ns/1ns
module tb_memory_bank_decoder;
   logic core_clk_i, reset_n_i, rd_i, wr_i, game_n_i, exrom_n_i;
   logic cass_sense_i, port_sel_o, ram_cs_o, ram_we_o, lower_rom_cs_o;
   logic upper_rom_cs_o, char_rom_cs_o, cart_lo_cs_o, cart_hi_cs_o;
   logic video_cs_o, sound_cs_o, colour_cs_o, colour_nybble_o, keyb_cs_o;
   logic serial_cs_o, slot1_cs_o, slot2_cs_o, cass_write_o, cass_motor_o;
   logic [15:0] addr_i;
   logic [7:0]  wdata_i, port_rdata_o;
   logic [5:0]  port_out_o, port_oe_n_o;
   logic [11:0] sel_v;
   int          fails, checks, cyc;
   logic [15:0] t_a [14] = '{16'hA000, 16'hBFFF, 16'hE000, 16'hFFFF,
      16'hD000, 16'hD400, 16'hD800, 16'hDC00, 16'hDD00, 16'hDE00,
      16'hDF00, 16'hA000, 16'hE000, 16'h0800};
   logic [12:0] t_e [14] = '{13'h0200, 13'h0200, 13'h0100, 13'h0100,
      13'h0040, 13'h0020, 13'h0010, 13'h0008, 13'h0004, 13'h0002,
      13'h0001, 13'h1C00, 13'h1C00, 13'h0800};
   assign sel_v = {ram_cs_o, ram_we_o, lower_rom_cs_o, upper_rom_cs_o,
      char_rom_cs_o, video_cs_o, sound_cs_o, colour_cs_o, keyb_cs_o,
      serial_cs_o, slot1_cs_o, slot2_cs_o};
   mbd_core_model core (.clk_i(core_clk_i), .addr_o(addr_i), .rd_o(rd_i),
      .wr_o(wr_i), .wdata_o(wdata_i));
   mbd_decoder DUT (.core_clk_i, .reset_n_i, .addr_i, .rd_i, .wr_i,
      .wdata_i, .game_n_i, .exrom_n_i, .cass_sense_i, .port_rdata_o,
      .port_sel_o, .ram_cs_o, .ram_we_o, .lower_rom_cs_o, .upper_rom_cs_o,
      .char_rom_cs_o, .cart_lo_cs_o, .cart_hi_cs_o, .video_cs_o,
      .sound_cs_o, .colour_cs_o, .colour_nybble_o, .keyb_cs_o,
      .serial_cs_o, .slot1_cs_o, .slot2_cs_o, .port_out_o, .port_oe_n_o,
      .cass_write_o, .cass_motor_o);
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tick;
      @(posedge core_clk_i);
      #1;
   endtask : tick
   task automatic look(input logic [15:0] a, input logic w,
                       input logic [11:0] e);
      core.bus(a, ~w, w, 8'h00);
      #10;
      chk("sel", {4'h0, sel_v}, {4'h0, e});
   endtask : look
   task automatic pw(input logic [15:0] a, input logic [7:0] d);
      core.bus(a, 1'b0, 1'b1, d);
      core.idle;
   endtask : pw
   task automatic pr(input logic [15:0] a, input logic [7:0] e);
      core.bus(a, 1'b1, 1'b0, 8'h00);
      core.idle;
      chk("port", {8'h00, port_rdata_o}, {8'h00, e});
   endtask : pr
   task automatic stop_test;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      reset_n_i = 1'b0;
      game_n_i = 1'b1;
      exrom_n_i = 1'b1;
      cass_sense_i = 1'b0;
      repeat (10) tick;
      reset_n_i = 1'b1;
      chk("oe", {10'h000, port_oe_n_o}, 16'h0010);
      chk("motor", {15'h0000, cass_motor_o}, 16'h0001);
      pr(16'h0000, 8'h2F);
      pr(16'h0001, 8'h2F);
      for (int i = 0; i < 14; i++)
         look(t_a[i], t_e[i][12], t_e[i][11:0]);
      pw(16'h0001, 8'h3C);
      look(16'hA000, 1'b0, 12'h800);
      look(16'hE000, 1'b0, 12'h800);
      look(16'hD000, 1'b0, 12'h800);
      pw(16'h0001, 8'h3E);
      look(16'hC000, 1'b0, 12'h800);
      look(16'hA000, 1'b0, 12'h800);
      look(16'hD000, 1'b0, 12'h040);
      look(16'hE000, 1'b0, 12'h100);
      pw(16'h0001, 8'h3B);
      look(16'hD000, 1'b0, 12'h080);
      look(16'hD000, 1'b1, 12'hC00);
      tick;
      cass_sense_i = 1'b1;
      repeat (3) tick;
      pr(16'h0001, 8'h3B);
      chk("cw", {15'h0000, cass_write_o}, 16'h0001);
      core.bus(16'h0000, 1'b0, 1'b1, 8'hFF);
      pr(16'h0000, 8'h3F);
      chk("oe", {10'h000, port_oe_n_o}, 16'h0000);
      pw(16'h0000, 8'h2F);
      pw(16'h0001, 8'h07);
      chk("motor", {15'h0000, cass_motor_o}, 16'h0000);
      chk("out", {10'h000, port_out_o}, 16'h0007);
      exrom_n_i = 1'b0;
      repeat (3) tick;
      core.bus(16'h8000, 1'b1, 1'b0, 8'h00);
      #10;
      chk("clo", {15'h0000, cart_lo_cs_o}, 16'h0001);
      core.bus(16'h8002, 1'b1, 1'b0, 8'h00);
      #10;
      chk("clo", {15'h0000, cart_lo_cs_o}, 16'h0001);
      core.bus(16'h8008, 1'b1, 1'b0, 8'h00);
      #10;
      chk("clo", {15'h0000, cart_lo_cs_o}, 16'h0001);
      tick;
      exrom_n_i = 1'b1;
      game_n_i = 1'b0;
      repeat (3) tick;
      look(16'hA000, 1'b0, 12'h000);
      look(16'hD000, 1'b0, 12'h040);
      core.bus(16'hE000, 1'b1, 1'b0, 8'h00);
      #10;
      chk("chi", {15'h0000, cart_hi_cs_o}, 16'h0001);
      tick;
      exrom_n_i = 1'b0;
      repeat (3) tick;
      core.bus(16'hA000, 1'b1, 1'b0, 8'h00);
      #10;
      chk("chi", {15'h0000, cart_hi_cs_o}, 16'h0001);
      look(16'hA000, 1'b1, 12'hC00);
      tick;
      game_n_i = 1'b1;
      exrom_n_i = 1'b1;
      reset_n_i = 1'b0;
      repeat (2) tick;
      reset_n_i = 1'b1;
      chk("motor", {15'h0000, cass_motor_o}, 16'h0001);
      chk("out", {10'h000, port_out_o}, 16'h003F);
      look(16'hA000, 1'b0, 12'h200);
      core.idle;
      stop_test;
   end
endmodule : tb_memory_bank_decoder
bind mbd_decoder mbd_decoder_sva u_sva (.core_clk_i, .reset_n_i, .addr_i,
   .rd_i, .wr_i, .wdata_i, .game_n_i, .port_rdata_o, .port_sel_o, .ram_cs_o,
   .ram_we_o, .lower_rom_cs_o, .video_cs_o, .colour_cs_o, .colour_nybble_o,
   .keyb_cs_o, .port_oe_n_o, .cass_write_o, .cass_motor_o);
